// ### src/sem_pkg.sv
// Shared constants and carrier types for the secondary error mask and severity block.
// Assumes a configuration-access agent presents one access per request with byte enables.
`default_nettype none

package sem_pkg;

   // ==========================================================================
   // Register offsets (extended configuration byte addresses)
   localparam logic [11:0] SEM_STATUS_OFF  = 12'h12C;
   localparam logic [11:0] SEM_MASK_OFF    = 12'h130;
   localparam logic [11:0] SEM_SEV_OFF     = 12'h134;
   localparam logic [11:0] SEM_FIRST_OFF   = 12'h138;
   localparam logic [11:0] SEM_LOG0_OFF    = 12'h13C;
   localparam logic [11:0] SEM_LOG1_OFF    = 12'h140;
   localparam logic [11:0] SEM_LOG2_OFF    = 12'h144;
   localparam logic [11:0] SEM_LOG3_OFF    = 12'h148;

   // ==========================================================================
   // Field layouts and reset values
   localparam int          SEM_ERR_W       = 14;
   localparam logic [13:0] SEM_EFF_BITS    = 14'h1E8C;
   localparam logic [13:0] SEM_WR_BITS     = 14'h3FEE;
   localparam logic [13:0] SEM_MASK_RST    = 14'h17A8;
   localparam logic [13:0] SEM_SEV_RST     = 14'h1340;
   localparam logic [31:0] SEM_RSVD_BITS   = 32'hFFFF_C010;
   localparam int          SEM_CMD_LO_POS  = 4;
   localparam int          SEM_CMD_HI_POS  = 8;

   // ==========================================================================
   // Carriers
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [11:0] addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } sem_cfg_req_type;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
   } sem_cfg_rsp_type;

   typedef struct packed {
      logic [13:0] pulse;
      logic [31:0] addr_lo;
      logic [31:0] addr_hi;
      logic        dual;
      logic [3:0]  cmd_lo;
      logic [3:0]  cmd_hi;
   } sem_err_in_type;

   typedef struct packed {
      logic valid;
      logic fatal;
   } sem_msg_type;

   typedef struct packed {
      logic [13:0]     mask;
      logic [13:0]     sev;
      logic [13:0]     status;
      logic [4:0]      first_ptr;
      logic [31:0]     log_addr_lo;
      logic [31:0]     log_addr_hi;
      logic [3:0]      log_cmd_lo;
      logic [3:0]      log_cmd_hi;
      sem_cfg_rsp_type rsp;
      sem_msg_type     msg;
   } sem_state_type;

   localparam sem_state_type SEM_STATE_RST = '{
      mask:        SEM_MASK_RST,
      sev:         SEM_SEV_RST,
      status:      14'h0000,
      first_ptr:   5'h00,
      log_addr_lo: 32'h0000_0000,
      log_addr_hi: 32'h0000_0000,
      log_cmd_lo:  4'h0,
      log_cmd_hi:  4'h0,
      rsp:         '{ack: 1'b0, rdata: 32'h0000_0000},
      msg:         '{valid: 1'b0, fatal: 1'b0}
   };

   typedef struct packed {
      logic [1:0] stage1;
      logic [1:0] stage2;
      logic       soft_rst;
   } sem_sync_state_type;

endpackage : sem_pkg

`default_nettype wire

// ### src/sem_reset_sync.sv
// Two-flop synchronisers for the fundamental and global reset pins, merged into one
// synchronous soft reset. Assumes both pins are asynchronous to clk_sys.
`default_nettype none

module sem_reset_sync
   import sem_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic fundamental_reset_in,
   input  wire logic global_reset_in,
   output var  logic soft_rst
);

   sem_sync_state_type st;
   sem_sync_state_type next_st;

   // ==========================================================================
   // First stage feeds only the second stage
   always_comb
   begin
      next_st          = st;
      next_st.stage1   = {global_reset_in, fundamental_reset_in};
      next_st.stage2   = st.stage1;
      next_st.soft_rst = |st.stage2;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         st <= '{stage1: 2'b00, stage2: 2'b00, soft_rst: 1'b1};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign soft_rst = st.soft_rst;

endmodule // sem_reset_sync

`default_nettype wire

// ### src/sem_error_regs.sv
// Secondary error mask and severity registers with the status, first pointer and
// header log they gate. Assumes bridge logic on clk_sys pulses err_in one cycle per error.
//
// What this block does
// - A set mask bit blocks status, message, header log and first pointer.
// - Unmasked error is fatal when its severity bit is one, else nonfatal.
// - Bits 12,11,10,9,7,3,2 are writable effective masks; one masks.
// - Mask register resets to 0000_17A8h.
// - Mask bits 13,8,6,5,1 are storage only; bit 0 reads zero.
// - Severity one selects fatal message, zero nonfatal.
// - Severity bits 13,8,6,5,1 are storage only; bit 0 read-only.
// - Severity register resets to 0000_1340h.
// - Bits 31:14 and bit 4 read zero and ignore writes.
// - Fundamental, global or power-on reset restores register defaults.
// - Mask register sits at offset 130h.
// - Severity register sits at offset 134h.
// - Status bits clear only by writing one; set wins over clear.
// - First pointer records bit position of first unmasked error.
// - Header log captures address and command of the erroring cycle.
`default_nettype none

module sem_error_regs
   import sem_pkg::*;
(
   input  wire logic            clk_sys,
   input  wire logic            rst,
   input  wire logic            fundamental_reset_in,
   input  wire logic            global_reset_in,
   input  wire sem_cfg_req_type cfg_req,
   output var  sem_cfg_rsp_type cfg_rsp,
   input  wire sem_err_in_type  err_in,
   output var  sem_msg_type     msg
);

   sem_state_type st;
   sem_state_type next_st;
   logic          soft_rst;
   logic [13:0]   live;
   logic [31:0]   wr_word;
   logic [13:0]   clr_bits;
   logic [13:0]   masked_new;
   logic          live_fatal;
   logic          first_empty;
   logic [4:0]    first_idx;

   // ==========================================================================
   // Helpers
   function automatic logic [31:0] be_merge(input logic [31:0] old_word,
                                            input logic [31:0] new_word,
                                            input logic [3:0]  be);
      logic [31:0] res;
      res = old_word;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            res[8*i +: 8] = new_word[8*i +: 8];
         end
      end
      return res;
   endfunction

   // Merge enabled bytes, then keep bit 0 and reserved bit 4 at their stored zero
   function automatic logic [13:0] field_write(input logic [13:0] old_val,
                                               input logic [31:0] new_word,
                                               input logic [3:0]  be);
      logic [31:0] merged;
      merged = be_merge({18'h0_0000, old_val}, new_word, be);
      return (merged[13:0] & SEM_WR_BITS) | (old_val & ~SEM_WR_BITS);
   endfunction

   function automatic logic [4:0] lowest_bit(input logic [13:0] vec);
      logic [4:0] idx;
      idx = 5'h00;
      for (int i = SEM_ERR_W - 1; i >= 0; i--)
      begin
         if (vec[i])
         begin
            idx = 5'(i);
         end
      end
      return idx;
   endfunction

   function automatic logic [31:0] read_word(input logic [11:0]   addr,
                                             input sem_state_type s);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (addr)
         SEM_STATUS_OFF: w = {18'h0_0000, s.status};
         SEM_MASK_OFF:   w = {18'h0_0000, s.mask} & ~SEM_RSVD_BITS;
         SEM_SEV_OFF:    w = {18'h0_0000, s.sev} & ~SEM_RSVD_BITS;
         SEM_FIRST_OFF:  w = {27'h000_0000, s.first_ptr};
         SEM_LOG1_OFF:   w = {20'h0_0000, s.log_cmd_hi, s.log_cmd_lo, 4'h0};
         SEM_LOG2_OFF:   w = s.log_addr_lo;
         SEM_LOG3_OFF:   w = s.log_addr_hi;
         default:        w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   // ==========================================================================
   // Reset pins are asynchronous, so they pass the synchroniser first
   sem_reset_sync u_reset_sync (
      .clk_sys              (clk_sys),
      .rst                  (rst),
      .fundamental_reset_in (fundamental_reset_in),
      .global_reset_in      (global_reset_in),
      .soft_rst             (soft_rst)
   );

   // ==========================================================================
   // Error qualification uses the mask of this very cycle, so a write landing
   // together with an error only affects later errors
   always_comb
   begin
      live        = err_in.pulse & SEM_EFF_BITS & ~st.mask;
      masked_new  = err_in.pulse & SEM_EFF_BITS & st.mask & ~st.status;
      live_fatal  = |(live & st.sev);
      // Byte enables applied once; the status clear reads only the low field
      wr_word     = be_merge(32'h0000_0000, cfg_req.wdata, cfg_req.be);
      clr_bits    = 14'h0000;
      if (cfg_req.valid && cfg_req.write && cfg_req.addr == SEM_STATUS_OFF)
      begin
         clr_bits = wr_word[13:0] & SEM_EFF_BITS;
      end
      first_empty = (st.status & ~clr_bits) == 14'h0000;
      first_idx   = lowest_bit(live);
   end

   // ==========================================================================
   // Next-state logic
   always_comb
   begin
      next_st           = st;
      next_st.rsp.ack   = 1'b0;
      next_st.msg.valid = 1'b0;
      next_st.msg.fatal = 1'b0;

      if (cfg_req.valid)
      begin
         next_st.rsp.ack   = 1'b1;
         next_st.rsp.rdata = read_word(cfg_req.addr, st);
         if (cfg_req.write && cfg_req.addr == SEM_MASK_OFF)
         begin
            next_st.mask = field_write(st.mask, cfg_req.wdata, cfg_req.be);
         end
         if (cfg_req.write && cfg_req.addr == SEM_SEV_OFF)
         begin
            next_st.sev = field_write(st.sev, cfg_req.wdata, cfg_req.be);
         end
      end

      // Hardware set is applied after the software clear so it wins
      next_st.status = (st.status & ~clr_bits) | live;

      if (live != 14'h0000)
      begin
         next_st.msg.valid   = 1'b1;
         next_st.msg.fatal   = live_fatal;
         next_st.log_addr_lo = err_in.addr_lo;
         next_st.log_addr_hi = err_in.dual ? err_in.addr_hi : 32'h0000_0000;
         next_st.log_cmd_lo  = err_in.cmd_lo;
         next_st.log_cmd_hi  = err_in.dual ? err_in.cmd_hi : 4'h0;
         if (first_empty)
         begin
            next_st.first_ptr = first_idx;
         end
      end

      // Fundamental or global reset reloads every field
      if (soft_rst)
      begin
         next_st = SEM_STATE_RST;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         st <= SEM_STATE_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign cfg_rsp = st.rsp;
   assign msg     = st.msg;

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst || soft_rst);
   // Soft reset reloads every field, so the checks pause while it stands

   a_masked_no_status: assert property ((masked_new != 14'h0000)
      |=> ((st.status & $past(masked_new)) == 14'h0000))
      else $error("Masked error set its status bit");

   a_masked_no_msg: assert property ((live == 14'h0000) |=> !msg.valid)
      else $error("Message sent with no unmasked error");

   a_masked_log_hold: assert property ((live == 14'h0000) |=> $stable(st.log_addr_lo)
      && $stable(st.first_ptr))
      else $error("Header log or pointer moved without unmasked error");

   a_unmasked_class: assert property ((live != 14'h0000)
      |=> msg.valid && (msg.fatal == $past(live_fatal)))
      else $error("Unmasked error reported with wrong class");

   a_noeffect_bits: assert property (((err_in.pulse & SEM_EFF_BITS) == 14'h0000)
      |=> !msg.valid && ((st.status & ~SEM_EFF_BITS) == 14'h0000))
      else $error("Non-effective bit caused reporting");

   a_rsvd_read_zero: assert property (cfg_req.valid && !cfg_req.write
      && (cfg_req.addr == SEM_MASK_OFF || cfg_req.addr == SEM_SEV_OFF)
      |=> cfg_rsp.ack && ((cfg_rsp.rdata & SEM_RSVD_BITS) == 32'h0000_0000))
      else $error("Reserved bits read non-zero");

   a_mask_readback: assert property (cfg_req.valid && !cfg_req.write && cfg_req.addr == SEM_MASK_OFF
      |=> cfg_rsp.rdata == {18'h0_0000, $past(st.mask)})
      else $error("Mask read does not match mask register");

   a_sev_readback: assert property (cfg_req.valid && !cfg_req.write && cfg_req.addr == SEM_SEV_OFF
      |=> cfg_rsp.rdata == {18'h0_0000, $past(st.sev)})
      else $error("Severity read does not match severity register");

   a_set_wins: assert property ((live != 14'h0000)
      |=> ((st.status & $past(live)) == $past(live)))
      else $error("Status set lost against clear");

   a_first_pointer: assert property ((live != 14'h0000) && first_empty
      |=> st.first_ptr == $past(first_idx))
      else $error("First error pointer not loaded");

   a_log_capture: assert property ((live != 14'h0000)
      |=> st.log_addr_lo == $past(err_in.addr_lo) && st.log_cmd_lo == $past(err_in.cmd_lo))
      else $error("Header log not captured");

   // Soft reset is the antecedent here, so only power-on reset disables it
   a_soft_defaults: assert property (@(posedge clk_sys) disable iff (rst)
      soft_rst |=> st.mask == SEM_MASK_RST && st.sev == SEM_SEV_RST && st.status == 14'h0000)
      else $error("Soft reset did not restore defaults");

   // ==========================================================================
   // Register access, status, message, pointer and log checks
   a_rsvd_no_store: assert property (((st.mask | st.sev) & ~SEM_WR_BITS) == 14'h0000)
      else $error("Read-only mask or severity bit holds a one");

   a_mask_write: assert property (cfg_req.valid && cfg_req.write && cfg_req.addr == SEM_MASK_OFF
      && cfg_req.be == 4'hF
      |=> st.mask == ($past(cfg_req.wdata[13:0]) & SEM_WR_BITS))
      else $error("Full mask write did not land");

   a_sev_write: assert property (cfg_req.valid && cfg_req.write && cfg_req.addr == SEM_SEV_OFF
      && cfg_req.be == 4'hF
      |=> st.sev == ($past(cfg_req.wdata[13:0]) & SEM_WR_BITS))
      else $error("Full severity write did not land");

   a_other_write: assert property (cfg_req.valid && cfg_req.write
      && cfg_req.addr != SEM_MASK_OFF && cfg_req.addr != SEM_SEV_OFF
      |=> $stable(st.mask) && $stable(st.sev))
      else $error("Write elsewhere changed mask or severity");

   a_clear_status: assert property ((clr_bits != 14'h0000) && (live == 14'h0000)
      |=> (st.status & $past(clr_bits)) == 14'h0000)
      else $error("Write of one did not clear status");

   a_status_sticky: assert property ((clr_bits == 14'h0000)
      |=> (st.status & $past(st.status)) == $past(st.status))
      else $error("Status bit dropped without a clear");

   a_unmasked_msg: assert property ((err_in.pulse & SEM_EFF_BITS & ~st.mask) != 14'h0000
      |=> msg.valid)
      else $error("Unmasked error sent no message");

   a_fatal_idle: assert property (!msg.valid |-> !msg.fatal)
      else $error("Fatal flag raised without a message");

   a_first_hold: assert property (!first_empty |=> $stable(st.first_ptr))
      else $error("First pointer moved while status was pending");

   a_log_single: assert property ((live != 14'h0000) && !err_in.dual
      |=> st.log_addr_hi == 32'h0000_0000 && st.log_cmd_hi == 4'h0)
      else $error("Single address cycle left high log fields");

   // ==========================================================================
   // Scenario covers
   c_fatal_msg:    cover property (msg.valid && msg.fatal);
   c_nonfatal_msg: cover property (msg.valid && !msg.fatal);
   c_mask_write:   cover property (cfg_req.valid && cfg_req.write && cfg_req.addr == SEM_MASK_OFF);
   c_clear_status: cover property (clr_bits != 14'h0000 && st.status != 14'h0000);
   c_pin_reset:    cover property (@(posedge clk_sys) disable iff (rst) soft_rst);

endmodule // sem_error_regs

`default_nettype wire

// ### testbench/sem_host_model.sv
// Host-side partner: issues configuration accesses and raises bridge error pulses.
// Assumes ack and msg each answer one cycle after the request edge.
`default_nettype none

module sem_host_model
   import sem_pkg::*;
(
   input  wire logic            clk_sys,
   input  wire sem_cfg_rsp_type cfg_rsp,
   input  wire sem_msg_type     msg,
   output var  sem_cfg_req_type cfg_req,
   output var  sem_err_in_type  err_in
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      cfg_req = '0;
      err_in  = '0;
   end

   // ==========================================================================
   // One access: request stands for the taking edge, answer read after it
   task access(input logic wr, input logic [11:0] a, input logic [31:0] d,
               output logic [31:0] q, output logic k);
      @(posedge clk_sys);
      #1;
      cfg_req = '{valid: 1'b1, write: wr, addr: a, be: 4'hF, wdata: d};
      @(posedge clk_sys);
      #1;
      // Released data must not keep showing the old word
      cfg_req.valid = 1'b0;
      cfg_req.wdata = ~d;
      q = cfg_rsp.rdata;
      k = cfg_rsp.ack;
   endtask

   // ==========================================================================
   // One error cycle: address and command travel with the pulse
   task error(input logic [13:0] p, input logic [31:0] a, output sem_msg_type m);
      @(posedge clk_sys);
      #1;
      err_in = '{pulse: p, addr_lo: a, addr_hi: ~a, dual: 1'b0, cmd_lo: 4'h7, cmd_hi: 4'h0};
      @(posedge clk_sys);
      #1;
      err_in.pulse   = 14'h0000;
      err_in.addr_lo = ~a;
      m = msg;
   endtask
endmodule // sem_host_model

`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the secondary error mask and severity registers.
// Assumes the host model drives the configuration port and the error pulses.
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module testbench
   import sem_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic            clk_sys = 1'b0;
   logic            rst = 1'b1;
   logic            fundamental_reset_in = 1'b0;
   logic            global_reset_in = 1'b0;
   sem_cfg_req_type cfg_req;
   sem_cfg_rsp_type cfg_rsp;
   sem_err_in_type  err_in;
   sem_msg_type     msg;
   int              failures = 0;
   int              n_tests = 0;
   int              cycles = 0;
   logic [31:0]     q;
   logic            k;
   sem_msg_type     m;
   int              eff [7] = '{12, 11, 10, 9, 7, 3, 2};
   logic [13:0]     sev_val = 14'h1284;

   always #12.5 clk_sys = ~clk_sys;

   sem_error_regs uut (
      .clk_sys              (clk_sys),
      .rst                  (rst),
      .fundamental_reset_in (fundamental_reset_in),
      .global_reset_in      (global_reset_in),
      .cfg_req              (cfg_req),
      .cfg_rsp              (cfg_rsp),
      .err_in               (err_in),
      .msg                  (msg)
   );

   sem_host_model host (
      .clk_sys (clk_sys),
      .cfg_rsp (cfg_rsp),
      .msg     (msg),
      .cfg_req (cfg_req),
      .err_in  (err_in)
   );

   // ==========================================================================
   // Access helpers
   task rd(input logic [11:0] a, input logic [31:0] e);
      host.access(1'b0, a, 32'h0000_0000, q, k);
      `CHK("ack", 1'b1, k)
      `CHK($sformatf("read %h", a), e, q)
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      host.access(1'b1, a, d, q, k);
      `CHK("ack", 1'b1, k)
   endtask

   task hit(input logic [13:0] p, input logic ev, input logic ef);
      host.error(p, 32'hA5A5_0000 | {18'h0_0000, p}, m);
      `CHK("msg valid", ev, m.valid)
      `CHK("msg fatal", ef, m.fatal)
   endtask

   // Pin held two cycles, then time for the synchroniser to let go
   task pin_reset(input logic g);
      @(posedge clk_sys);
      #1;
      global_reset_in      = g;
      fundamental_reset_in = ~g;
      repeat (2) @(posedge clk_sys);
      #1;
      global_reset_in      = 1'b0;
      fundamental_reset_in = 1'b0;
      repeat (6) @(posedge clk_sys);
   endtask

   task stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Run takes about 100 cycles; ceiling leaves ample margin
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         stop_test;
      end
   end

   // ==========================================================================
   // Test sequence
   initial
   begin
      repeat (5) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      repeat (5) @(posedge clk_sys);
      rd(12'h130, 32'h0000_17A8);
      rd(12'h134, 32'h0000_1340);
      rd(12'h200, 32'h0000_0000);
      $display("test reset values done");

      wr(12'h130, 32'hFFFF_FFFF);
      rd(12'h130, 32'h0000_3FEE);
      wr(12'h134, 32'hFFFF_FFFF);
      rd(12'h134, 32'h0000_3FEE);
      hit(14'h1E8C, 1'b0, 1'b0);
      rd(12'h12C, 32'h0000_0000);
      rd(12'h144, 32'h0000_0000);
      $display("test masked errors done");

      wr(12'h130, 32'h0000_0000);
      wr(12'h134, {18'h0_0000, sev_val});
      foreach (eff[i])
      begin
         hit(14'h0001 << eff[i], 1'b1, sev_val[eff[i]]);
      end
      rd(12'h138, 32'h0000_000C);
      rd(12'h144, 32'hA5A5_0004);
      rd(12'h140, 32'h0000_0070);
      rd(12'h148, 32'h0000_0000);
      rd(12'h12C, 32'h0000_1E8C);
      hit(14'h2162, 1'b0, 1'b0);
      rd(12'h12C, 32'h0000_1E8C);
      wr(12'h12C, 32'h0000_1000);
      rd(12'h12C, 32'h0000_0E8C);
      $display("test unmasked errors done");

      pin_reset(1'b0);
      rd(12'h134, 32'h0000_1340);
      wr(12'h130, 32'h0000_0000);
      pin_reset(1'b1);
      rd(12'h130, 32'h0000_17A8);
      rd(12'h12C, 32'h0000_0000);
      hit(14'h1000, 1'b0, 1'b0);
      hit(14'h0800, 1'b1, 1'b0);
      rd(12'h12C, 32'h0000_0800);
      rd(12'h138, 32'h0000_000B);
      $display("test pin resets done");
      stop_test;
   end
endmodule // testbench

`default_nettype wire
